// *** hdl/sbp_array.sv ***
`timescale 1ns/1ps
// Storage array with a registered read port; the read register is the device output stage.
module sbp_array (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Access
    input wire logic [sbp_pkg::ADDR_W-1:0] addr,
    input wire logic wr_en,
    input wire logic [sbp_pkg::LANES-1:0] wr_lanes,
    input wire logic [sbp_pkg::WORD_W-1:0] wr_word,
    input wire logic rd_en,
    output logic [sbp_pkg::WORD_W-1:0] rd_word
);
    logic [sbp_pkg::WORD_W-1:0] mem [0:sbp_pkg::DEPTH-1];
    logic [sbp_pkg::WORD_W-1:0] next_rd_word;

    // The output register holds its word until the next read, so a suspended burst keeps its data.
    always_comb begin
        next_rd_word = rd_word;
        if (rd_en) begin
            next_rd_word = mem[addr];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rd_word <= '0;
        end else begin
            rd_word <= next_rd_word;
        end
    end

    // Only the selected lanes are written; unselected lanes keep their contents.
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            for (int k = 0; k < sbp_pkg::LANES; k++) begin
                if (wr_lanes[k]) begin
                    mem[addr][k*sbp_pkg::LANE_W +: sbp_pkg::LANE_W] <= wr_word[k*sbp_pkg::LANE_W +: sbp_pkg::LANE_W];
                end
            end
        end
    end
endmodule

// *** hdl/sbp_burst_sram.sv ***
`timescale 1ns/1ps
// Behaviour
// - Every synchronous input is captured in an input register on the rising clock edge.
// - A new address and chip-enable state are taken only on an edge where either address strobe is active.
// - After the first address, later burst addresses are made internally and step only on burst advance.
// - A two-bit counter modifies the lowest two bits of the latched address during a burst.
// - The burst order is interleaved or linear, chosen by a static configuration input.
// - A write registers address, data and write controls and then completes in an internally timed cycle.
// - Byte lane write controls select which lanes are written, so a write covers any combination of the four bytes.
// - A low global write input writes all lanes regardless of the lane controls.
// - Output enable and the sleep input both act on the data drivers without the clock.
// - A dedicated sleep input puts the device in a low-power mode.
// - Inputs and outputs are both registered, so read data leaves through an output register.
// - A burst read gives its first word three clocks after the strobe and one word per clock after that.
// - The device deselects within one clock once a deselecting chip-enable set is registered with an address strobe.
// - Two extra chip enables for depth expansion are registered and qualify every strobe-started burst with the primary one.
// - The array holds 524,288 words of 36 bits; the 1,048,576-word 18-bit organisation exists only as unused package constants.
module sbp_burst_sram (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Address and burst control
    input wire logic [sbp_pkg::ADDR_W-1:0] addr,
    input wire logic processor_addr_strobe_n,
    input wire logic controller_addr_strobe_n,
    input wire logic burst_advance_n,
    input wire logic burst_order_linear,
    // Chip enables
    input wire logic chip_select_primary_n,
    input wire logic chip_select_depth_hi,
    input wire logic chip_select_depth_lo_n,
    // Write controls
    input wire logic all_bytes_write_n,
    input wire logic byte_write_enable_n,
    input wire logic [sbp_pkg::LANES-1:0] byte_lane_write_n,
    // Asynchronous controls
    input wire logic output_enable_n,
    input wire logic sleep_request,
    // Data pins, split into input, output and enable
    input wire logic [sbp_pkg::DATA_W-1:0] data_in,
    output logic [sbp_pkg::DATA_W-1:0] data_out,
    output logic data_oe,
    input wire logic [sbp_pkg::LANES-1:0] parity_data_in,
    output logic [sbp_pkg::LANES-1:0] parity_data_out,
    output logic parity_data_oe
);
    // Input register stage.
    logic [sbp_pkg::ADDR_W-1:0] in_addr;
    logic in_ps_n, in_cs_n, in_advance_n, in_linear;
    logic in_sel_primary_n, in_sel_hi, in_sel_lo_n, in_all_wr_n, in_lane_wr_en_n;
    logic [sbp_pkg::LANES-1:0] in_bw_n;
    logic [sbp_pkg::WORD_W-1:0] in_word;
    // Control and access stage.
    sbp_pkg::sbp_state_t state, next_state;
    logic [sbp_pkg::ADDR_W-1:0] base_addr, next_base_addr, acc_addr, next_acc_addr;
    logic [sbp_pkg::BURST_W-1:0] cnt, next_cnt;
    logic acc_rd, next_acc_rd, acc_wr, next_acc_wr, out_drive, next_out_drive;
    logic [sbp_pkg::LANES-1:0] acc_lanes, next_acc_lanes;
    logic [sbp_pkg::WORD_W-1:0] acc_word, next_acc_word, rd_word;
    logic sleep_meta, sleep_q;
    logic sel, start, wr_req, issue_rd;
    logic [sbp_pkg::LANES-1:0] req_lanes;

    // Low address bits for a burst step; interleaved order flips bits, linear order adds and wraps.
    function automatic logic [sbp_pkg::ADDR_W-1:0] burst_addr(input logic [sbp_pkg::ADDR_W-1:0] base,
                                                              input logic [sbp_pkg::BURST_W-1:0] step,
                                                              input logic linear);
        logic [sbp_pkg::ADDR_W-1:0] res;
        res = base;
        if (linear) begin
            res[sbp_pkg::BURST_W-1:0] = base[sbp_pkg::BURST_W-1:0] + step;
        end else begin
            res[sbp_pkg::BURST_W-1:0] = base[sbp_pkg::BURST_W-1:0] ^ step;
        end
        return res;
    endfunction

    // All synchronous pins are captured here first; nothing downstream looks at a raw pin.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            in_addr <= '0;
            in_ps_n <= 1'b1;
            in_cs_n <= 1'b1;
            in_advance_n <= 1'b1;
            in_linear <= 1'b0;
            in_sel_primary_n <= 1'b1;
            in_sel_hi <= 1'b0;
            in_sel_lo_n <= 1'b1;
            in_all_wr_n <= 1'b1;
            in_lane_wr_en_n <= 1'b1;
            in_bw_n <= sbp_pkg::LANES_ALL;
            in_word <= '0;
        end else begin
            in_addr <= addr;
            in_ps_n <= processor_addr_strobe_n;
            in_cs_n <= controller_addr_strobe_n;
            in_advance_n <= burst_advance_n;
            in_linear <= burst_order_linear;
            in_sel_primary_n <= chip_select_primary_n;
            in_sel_hi <= chip_select_depth_hi;
            in_sel_lo_n <= chip_select_depth_lo_n;
            in_all_wr_n <= all_bytes_write_n;
            in_lane_wr_en_n <= byte_write_enable_n;
            in_bw_n <= byte_lane_write_n;
            for (int k = 0; k < sbp_pkg::LANES; k++) begin
                in_word[k*sbp_pkg::LANE_W +: sbp_pkg::LANE_W] <=
                    {parity_data_in[k], data_in[k*sbp_pkg::LANE_DATA_W +: sbp_pkg::LANE_DATA_W]};
            end
        end
    end

    // The sleep pin is asynchronous, so it is synchronised before the state machine acts on it.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sleep_meta <= 1'b0;
            sleep_q <= 1'b0;
        end else begin
            sleep_meta <= sleep_request;
            sleep_q <= sleep_meta;
        end
    end

    // Decode of the registered controls.
    assign sel = ~in_sel_primary_n & in_sel_hi & ~in_sel_lo_n;
    assign start = ~in_ps_n | ~in_cs_n;
    assign req_lanes = ~in_all_wr_n ? sbp_pkg::LANES_ALL :
                       (~in_lane_wr_en_n ? ~in_bw_n : sbp_pkg::LANES_NONE);
    assign wr_req = req_lanes != sbp_pkg::LANES_NONE;
    assign issue_rd = next_acc_rd;

    // Burst control; a cycle with no advance repeats the access at the current address.
    always_comb begin
        next_state = state;
        next_base_addr = base_addr;
        next_cnt = cnt;
        next_acc_addr = acc_addr;
        next_acc_word = in_word;
        next_acc_lanes = sbp_pkg::LANES_NONE;
        next_acc_rd = 1'b0;
        next_acc_wr = 1'b0;
        next_out_drive = acc_rd;
        case (state)
            sbp_pkg::ST_SLEEP: begin
                if (!sleep_q) begin
                    next_state = sbp_pkg::ST_IDLE;
                end
            end
            sbp_pkg::ST_IDLE, sbp_pkg::ST_BURST: begin
                if (sleep_q) begin
                    next_state = sbp_pkg::ST_SLEEP;
                end else if (start) begin
                    if (sel) begin
                        next_state = sbp_pkg::ST_BURST;
                        next_base_addr = in_addr;
                        next_cnt = sbp_pkg::BURST_START;
                        next_acc_addr = in_addr;
                        // A processor-strobe start is always a read; writes follow in later cycles.
                        next_acc_wr = in_ps_n & wr_req;
                        next_acc_rd = ~(in_ps_n & wr_req);
                        next_acc_lanes = req_lanes;
                    end else begin
                        next_state = sbp_pkg::ST_IDLE;
                    end
                end else if (state == sbp_pkg::ST_BURST) begin
                    if (!in_advance_n) begin
                        next_cnt = cnt + sbp_pkg::BURST_STEP;
                    end
                    next_acc_addr = burst_addr(base_addr, next_cnt, in_linear);
                    next_acc_wr = wr_req;
                    next_acc_rd = ~wr_req;
                    next_acc_lanes = req_lanes;
                end
            end
            default: begin
                next_state = sbp_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= sbp_pkg::ST_IDLE;
            base_addr <= '0;
            cnt <= sbp_pkg::BURST_START;
            acc_addr <= '0;
            acc_word <= '0;
            acc_lanes <= sbp_pkg::LANES_NONE;
            acc_rd <= 1'b0;
            acc_wr <= 1'b0;
            out_drive <= 1'b0;
        end else begin
            state <= next_state;
            base_addr <= next_base_addr;
            cnt <= next_cnt;
            acc_addr <= next_acc_addr;
            acc_word <= next_acc_word;
            acc_lanes <= next_acc_lanes;
            acc_rd <= next_acc_rd;
            acc_wr <= next_acc_wr;
            out_drive <= next_out_drive;
        end
    end

    // Array with its output register; writes land one edge after the access stage.
    sbp_array u_array (
        .clk_sys(clk_sys),
        .rst(rst),
        .addr(acc_addr),
        .wr_en(acc_wr),
        .wr_lanes(acc_lanes),
        .wr_word(acc_word),
        .rd_en(acc_rd),
        .rd_word(rd_word)
    );

    // Unpack the output register into data and parity pins.
    always_comb begin
        for (int k = 0; k < sbp_pkg::LANES; k++) begin
            data_out[k*sbp_pkg::LANE_DATA_W +: sbp_pkg::LANE_DATA_W] =
                rd_word[k*sbp_pkg::LANE_W +: sbp_pkg::LANE_DATA_W];
            parity_data_out[k] = rd_word[k*sbp_pkg::LANE_W + sbp_pkg::LANE_DATA_W];
        end
    end

    // Output enable and sleep gate the drivers with no clock in the path, trading glitch-free enables for speed.
    assign data_oe = out_drive & ~output_enable_n & ~sleep_request;
    assign parity_data_oe = data_oe;

    sequence rd_issued;
        issue_rd;
    endsequence

    sequence word_out;
        ##1 acc_rd ##1 out_drive;
    endsequence

    AST_INPUT_TO_ARRAY: assert property (@(posedge clk_sys) disable iff (rst)
        acc_wr |-> acc_word[sbp_pkg::LANE_DATA_W-1:0] == $past(data_in[sbp_pkg::LANE_DATA_W-1:0], 2))
        else $error("write data is not the word sampled two edges earlier");
    AST_BASE_HELD: assert property (@(posedge clk_sys) disable iff (rst)
        !start |=> base_addr == $past(base_addr))
        else $error("base address changed without a strobe");
    AST_COUNT_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
        (state == sbp_pkg::ST_BURST && !start && in_advance_n && !sleep_q) |=> cnt == $past(cnt))
        else $error("burst counter moved without advance");
    AST_COUNT_STEP: assert property (@(posedge clk_sys) disable iff (rst)
        (state == sbp_pkg::ST_BURST && !start && !in_advance_n && !sleep_q) |=> cnt == $past(cnt) + 2'h1)
        else $error("burst counter did not step and wrap");
    AST_INTERLEAVE: assert property (@(posedge clk_sys) disable iff (rst)
        (state == sbp_pkg::ST_BURST && !start && !in_linear && !sleep_q) |=>
            acc_addr == {base_addr[sbp_pkg::ADDR_W-1:2], base_addr[1:0] ^ cnt})
        else $error("interleaved burst address wrong");
    AST_GLOBAL_WRITE: assert property (@(posedge clk_sys) disable iff (rst)
        (!in_all_wr_n && next_acc_wr) |=> acc_wr && acc_lanes == sbp_pkg::LANES_ALL)
        else $error("global write did not select all lanes");
    AST_FIRST_WORD: assert property (@(posedge clk_sys) disable iff (rst)
        rd_issued |-> word_out)
        else $error("read word not out two edges after the access decision");
    AST_DESELECT: assert property (@(posedge clk_sys) disable iff (rst)
        (start && !sel) |=> !acc_rd && !acc_wr && state == sbp_pkg::ST_IDLE)
        else $error("deselect did not stop the access");
    AST_OUT_REG: assert property (@(posedge clk_sys) disable iff (rst)
        out_drive |-> $past(acc_rd))
        else $error("drivers on without a registered read");
    AST_SLEEP_QUIET: assert property (@(posedge clk_sys) disable iff (rst)
        sleep_q |=> !acc_rd && !acc_wr)
        else $error("access issued during sleep");
endmodule

// *** hdl/sbp_pkg.sv ***
package sbp_pkg;
    // Organisation in use: 512K words of 36 bits, four lanes of eight data bits plus one parity bit.
    localparam int ADDR_W = 19;
    localparam int DEPTH = 524288;
    localparam int LANES = 4;
    localparam int LANE_DATA_W = 8;
    localparam int LANE_W = 9;
    localparam int WORD_W = 36;
    localparam int DATA_W = 32;
    // The other organisation: 1M words of 18 bits, two lanes.
    localparam int ALT_ADDR_W = 20;
    localparam int ALT_DEPTH = 1048576;
    localparam int ALT_LANES = 2;
    localparam int ALT_WORD_W = 18;
    // Burst counter width and pipeline figures.
    localparam int BURST_W = 2;
    localparam int FIRST_READ_CLOCKS = 3;
    localparam int NEXT_READ_CLOCKS = 1;
    // Reset values and the burst step.
    localparam logic [LANES-1:0] LANES_ALL = 4'hf;
    localparam logic [LANES-1:0] LANES_NONE = 4'h0;
    localparam logic [BURST_W-1:0] BURST_START = 2'h0;
    localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;

    // Control states, one-hot.
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_BURST = 3'b010,
        ST_SLEEP = 3'b100
    } sbp_state_t;
endpackage

// *** verification/sbp_burst_sram_tb.sv ***
`timescale 1ns/1ps
// Self-checking bench: table of writes read back, then bursts, output gating, sleep and deselect.
module sbp_burst_sram_tb;
    typedef struct packed {
        logic [18:0] a;
        logic g_n;
        logic e_n;
        logic [3:0] l_n;
        logic [35:0] w;
    } sbp_row_t;
    // Full write, one lane, two lanes, global over lanes, no write, top address.
    localparam sbp_row_t ROWS [6] = '{
        '{19'h00010, 1'h1, 1'h0, 4'h0, 36'h9_1234_5678}, '{19'h00010, 1'h1, 1'h0, 4'he, 36'h0_0000_00aa},
        '{19'h00010, 1'h1, 1'h0, 4'h3, 36'hf_cafe_0000}, '{19'h00010, 1'h0, 1'h1, 4'hf, 36'h5_a5a5_a5a5},
        '{19'h00010, 1'h1, 1'h1, 4'h0, 36'h0_0000_0000}, '{19'h7ffff, 1'h0, 1'h1, 4'hf, 36'h3_0f0f_0f0f}};
    logic clk_sys;
    logic rst;
    logic output_enable_n;
    logic sleep_request;
    logic [sbp_pkg::ADDR_W-1:0] addr;
    logic ps_n, cs_n, advance_n, lin, sel_primary_n, sel_hi, sel_lo_n, g_n, e_n;
    logic [3:0] l_n, p_in, p_out;
    logic [31:0] d_in, d_out;
    logic data_oe, parity_data_oe;
    logic [36:0] q [4];
    logic [35:0] exp_mem [int];
    logic [1:0] st;
    logic [1:0] off;
    int n_fail;
    int checks;

    sbp_burst_sram u_dut (.clk_sys(clk_sys), .rst(rst), .addr(addr), .processor_addr_strobe_n(ps_n),
        .controller_addr_strobe_n(cs_n), .burst_advance_n(advance_n), .burst_order_linear(lin),
        .chip_select_primary_n(sel_primary_n), .chip_select_depth_hi(sel_hi), .chip_select_depth_lo_n(sel_lo_n),
        .all_bytes_write_n(g_n), .byte_write_enable_n(e_n), .byte_lane_write_n(l_n),
        .output_enable_n(output_enable_n), .sleep_request(sleep_request), .data_in(d_in), .data_out(d_out),
        .data_oe(data_oe), .parity_data_in(p_in), .parity_data_out(p_out), .parity_data_oe(parity_data_oe));
    sbp_bus_master u_m (.clk_sys(clk_sys), .addr(addr), .processor_addr_strobe_n(ps_n),
        .controller_addr_strobe_n(cs_n), .burst_advance_n(advance_n), .burst_order_linear(lin),
        .chip_select_primary_n(sel_primary_n), .chip_select_depth_hi(sel_hi), .chip_select_depth_lo_n(sel_lo_n),
        .all_bytes_write_n(g_n), .byte_write_enable_n(e_n), .byte_lane_write_n(l_n), .data_in(d_in),
        .parity_data_in(p_in), .data_out(d_out), .parity_data_out(p_out), .data_oe(data_oe));

    // Free-running 200 MHz clock.
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // Expected word after a write: a lane changes under the global write or its own enabled lane strobe.
    function automatic logic [35:0] merge(input logic [35:0] old, input sbp_row_t r);
        logic [35:0] m;
        m = old;
        for (int k = 0; k < 4; k++) begin
            if (!r.g_n || (!r.e_n && !r.l_n[k])) begin
                m[8*k +: 8] = r.w[8*k +: 8];
                m[32+k] = r.w[32+k];
            end
        end
        return m;
    endfunction

    task automatic chk_word(input string name, input logic [36:0] exp, input logic [36:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_bit(input string name, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Watchdog: the sequence needs well under a thousand clocks, so this only trips on a hang.
    initial begin
        repeat (5000) @(posedge clk_sys);
        n_fail++;
        finish_test();
    end

    initial begin
        n_fail = 0;
        checks = 0;
        rst = 1'b1;
        output_enable_n = 1'b0;
        sleep_request = 1'b0;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        #1 chk_bit("reset data_oe", 1'b0, data_oe);
        chk_word("reset data_out", 37'h0, {1'b0, p_out, d_out});
        $display("test reset done");
        // Table rows: write, then read back, alternating the two strobes.
        foreach (ROWS[i]) begin
            u_m.wr(ROWS[i].a, ROWS[i].g_n, ROWS[i].e_n, ROWS[i].l_n, ROWS[i].w);
            exp_mem[ROWS[i].a] = merge(exp_mem.exists(ROWS[i].a) ? exp_mem[ROWS[i].a] : 36'hx, ROWS[i]);
            u_m.rd(ROWS[i].a, i[0], 1'b0, 1, q);
            chk_word("row read", {1'b1, exp_mem[ROWS[i].a]}, q[0]);
        end
        $display("test rows done");
        // Bursts over one four-word group, both orders, starting mid-group so the burst address wraps.
        for (int j = 0; j < 4; j++) begin
            exp_mem[{17'h8, 2'(j)}] = {4'(j), 24'hc0ffee, 8'(j)};
            u_m.wr({17'h8, 2'(j)}, 1'b0, 1'b1, 4'hf, {4'(j), 24'hc0ffee, 8'(j)});
        end
        // A known word where the sleep test later tries a write, so a write that slips through shows.
        exp_mem[32'h20] = 36'h6_6666_6666;
        u_m.wr(19'h00020, 1'b0, 1'b1, 4'hf, 36'h6_6666_6666);
        for (int m = 0; m < 4; m++) begin
            st = m[0] ? 2'h3 : 2'h1;
            u_m.rd({17'h8, st}, m[0], m[1], 4, q);
            for (int k = 0; k < 4; k++) begin
                off = m[1] ? st + 2'(k) : st ^ 2'(k);
                chk_word("burst word", {1'b1, exp_mem[{17'h8, off}]}, q[k]);
            end
        end
        $display("test bursts done");
        // Output enable acts within the cycle, while the burst keeps the drivers on.
        @(posedge clk_sys);
        output_enable_n <= 1'b1;
        #1 chk_bit("oe off data", 1'b0, data_oe);
        chk_bit("oe off parity", 1'b0, parity_data_oe);
        @(posedge clk_sys);
        output_enable_n <= 1'b0;
        #1 chk_bit("oe on", 1'b1, data_oe);
        // Sleep gates drivers at once and blocks a write made while asleep.
        @(posedge clk_sys);
        sleep_request <= 1'b1;
        #1 chk_bit("sleep drivers", 1'b0, data_oe);
        repeat (3) @(posedge clk_sys);
        u_m.wr(19'h00020, 1'b0, 1'b1, 4'hf, 36'h0);
        repeat (3) @(posedge clk_sys);
        sleep_request <= 1'b0;
        repeat (4) @(posedge clk_sys);
        u_m.rd(19'h00020, 1'b0, 1'b0, 1, q);
        chk_word("after sleep", {1'b1, exp_mem[32'h20]}, q[0]);
        $display("test gating done");
        // Each chip enable alone deselects; the drivers are off when the first read word would appear.
        for (int d = 0; d < 3; d++) begin
            u_m.select_chip(d == 0, d != 1, d == 2);
            u_m.rd(19'h00020, 1'b0, 1'b0, 1, q);
            chk_bit("deselect oe", 1'b0, q[0][36]);
        end
        $display("test deselect done");
        finish_test();
    end
endmodule

// *** verification/sbp_bus_master.sv ***
`timescale 1ns/1ps
// Far-side bus master model; every pin change is made by non-blocking assignment at a rising edge.
module sbp_bus_master (
    // Clock
    input wire logic clk_sys,
    // Address and controls toward the memory
    output logic [sbp_pkg::ADDR_W-1:0] addr,
    output logic processor_addr_strobe_n,
    output logic controller_addr_strobe_n,
    output logic burst_advance_n,
    output logic burst_order_linear,
    output logic chip_select_primary_n,
    output logic chip_select_depth_hi,
    output logic chip_select_depth_lo_n,
    output logic all_bytes_write_n,
    output logic byte_write_enable_n,
    output logic [sbp_pkg::LANES-1:0] byte_lane_write_n,
    // Data
    output logic [sbp_pkg::DATA_W-1:0] data_in,
    output logic [sbp_pkg::LANES-1:0] parity_data_in,
    input wire logic [sbp_pkg::DATA_W-1:0] data_out,
    input wire logic [sbp_pkg::LANES-1:0] parity_data_out,
    input wire logic data_oe
);
    // Idle pins: no strobe, chip selected, no write controls active.
    initial begin
        addr = 19'h0;
        processor_addr_strobe_n = 1'b1;
        controller_addr_strobe_n = 1'b1;
        burst_advance_n = 1'b1;
        burst_order_linear = 1'b0;
        chip_select_primary_n = 1'b0;
        chip_select_depth_hi = 1'b1;
        chip_select_depth_lo_n = 1'b0;
        all_bytes_write_n = 1'b1;
        byte_write_enable_n = 1'b1;
        byte_lane_write_n = 4'hf;
        {parity_data_in, data_in} = 36'h0;
    end

    // One write per strobe. The controller strobe is used since a processor strobe always reads.
    // Released data and address show the inverse, so a late sample cannot match by luck.
    task automatic wr(input logic [18:0] a, input logic g_n, input logic e_n, input logic [3:0] l_n,
                      input logic [35:0] w);
        @(posedge clk_sys);
        addr <= a;
        controller_addr_strobe_n <= 1'b0;
        all_bytes_write_n <= g_n;
        byte_write_enable_n <= e_n;
        byte_lane_write_n <= l_n;
        {parity_data_in, data_in} <= w;
        @(posedge clk_sys);
        controller_addr_strobe_n <= 1'b1;
        all_bytes_write_n <= 1'b1;
        byte_write_enable_n <= 1'b1;
        {parity_data_in, data_in} <= ~w;
        addr <= ~a;
    endtask

    // Chip enables change at a rising edge like every other pin, so the bench never drives them itself.
    task automatic select_chip(input logic p_n, input logic hi, input logic lo_n);
        @(posedge clk_sys);
        chip_select_primary_n <= p_n;
        chip_select_depth_hi <= hi;
        chip_select_depth_lo_n <= lo_n;
    endtask

    // Read burst of n words; advance is held low just long enough for n-1 steps.
    task automatic rd(input logic [18:0] a, input logic proc, input logic lin, input int n,
                      output logic [36:0] q [4]);
        @(posedge clk_sys);
        addr <= a;
        burst_order_linear <= lin;
        if (proc) processor_addr_strobe_n <= 1'b0;
        else controller_addr_strobe_n <= 1'b0;
        @(posedge clk_sys);
        processor_addr_strobe_n <= 1'b1;
        controller_addr_strobe_n <= 1'b1;
        addr <= ~a;
        burst_advance_n <= (n < 2);
        @(posedge clk_sys);
        if (n < 3) burst_advance_n <= 1'b1;
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys);
            if (i + 3 == n) burst_advance_n <= 1'b1;
            #1 q[i] = {data_oe, parity_data_out, data_out};
        end
    endtask
endmodule
